// ===== shared/srad_map.vh
`ifndef SRAD_MAP_VH
`define SRAD_MAP_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SRAD_OFF_D0_LOW     12'h000
`define SRAD_OFF_D0_HIGH    12'h004
`define SRAD_OFF_D1_LOW     12'h008
`define SRAD_OFF_D1_HIGH    12'h00C
`define SRAD_OFF_D2_LOW     12'h010
`define SRAD_OFF_D2_HIGH    12'h014
`define SRAD_OFF_D3_LOW     12'h018
`define SRAD_OFF_D3_HIGH    12'h01C
`define SRAD_OFF_STATUS     12'h020
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SRAD_REGION_HI      31
`define SRAD_REGION_LO      28
`define SRAD_BOUND_HI       27
`define SRAD_BOUND_LO       20
`define SRAD_WIN_MASK       32'hFFF0_0000
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SRAD_RST_D0_LOW     32'h0000_0000
`define SRAD_RST_D0_HIGH    32'h007F_FFFF
`define SRAD_RST_D1_LOW     32'h0080_0000
`define SRAD_RST_D1_HIGH    32'h00FF_FFFF
`define SRAD_RST_D2_LOW     32'h0100_0000
`define SRAD_RST_D2_HIGH    32'h017F_FFFF
`define SRAD_RST_D3_LOW     32'h0180_0000
`define SRAD_RST_D3_HIGH    32'h01FF_FFFF
`endif

// ===== hdl/srad_window_match.v
`timescale 1ns/1ps
// ----------------------------------------
// One device window comparator
// ----------------------------------------
module srad_window_match (
   input  wire [31:0] addr,
   input  wire [31:0] win_low,
   input  wire [31:0] win_high,
   output wire        hit
);
   wire region_ok;
   wire low_ok;
   wire high_ok;

   assign region_ok = addr[31:28] == win_low[31:28];
   assign low_ok    = addr[27:20] >= win_low[27:20];
   assign high_ok   = addr[27:20] <= win_high[27:20];
   // Low above high makes low_ok and high_ok exclusive
   assign hit       = region_ok & low_ok & high_ok;
endmodule // srad_window_match

// ===== hdl/srad_decoder.v
// Summary of operation
// - Address space is sixteen 256 MB regions chosen by address bits 31 to 28.
// - A device hits only if address bits 31 to 28 equal its low register region field.
// - Address bits 27 to 20 must be at least the low register bound.
// - Address bits 27 to 20 must be at most the high register bound.
// - When all three checks hold for device n and bus_valid is high, chip select n is asserted low on the next clock.
// - A low bound above the high bound disables the device.
// - The high region field is forced to the low region field so crossings read back differently.
// - After reset the windows are four consecutive 8 MB ranges from zero.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "srad_map.vh"
module srad_decoder #(
   parameter NDEV = 4
) (
   input  wire            clock,
   input  wire            nrst,
   input  wire            psel,
   input  wire            penable,
   input  wire            pwrite,
   input  wire [11:0]     paddr,
   input  wire [31:0]     pwdata,
   output reg  [31:0]     prdata,
   output reg             pready,
   output reg             pslverr,
   input  wire            bus_valid,
   input  wire [31:0]     bus_physical_address,
   output reg  [NDEV-1:0] memory_chip_select_n,
   output reg             bus_unclaimed,
   output reg             bus_decoded
);
   // ----------------------------------------
   // Window registers and decode nets
   // ----------------------------------------
   reg  [31:0]     device0_window_low_q;
   reg  [31:0]     device0_window_low_d;
   reg  [31:0]     device0_window_high_q;
   reg  [31:0]     device0_window_high_d;
   reg  [31:0]     device1_window_low_q;
   reg  [31:0]     device1_window_low_d;
   reg  [31:0]     device1_window_high_q;
   reg  [31:0]     device1_window_high_d;
   reg  [31:0]     device2_window_low_q;
   reg  [31:0]     device2_window_low_d;
   reg  [31:0]     device2_window_high_q;
   reg  [31:0]     device2_window_high_d;
   reg  [31:0]     device3_window_low_q;
   reg  [31:0]     device3_window_low_d;
   reg  [31:0]     device3_window_high_q;
   reg  [31:0]     device3_window_high_d;
   reg  [11:0]     last_addr_q;
   reg             last_unclaimed_q;
   reg             sel_d0_low;
   reg             sel_d0_high;
   reg             sel_d1_low;
   reg             sel_d1_high;
   reg             sel_d2_low;
   reg             sel_d2_high;
   reg             sel_d3_low;
   reg             sel_d3_high;
   reg             sel_status;
   reg             sel_none;
   reg  [31:0]     rd_d;
   wire            acc;
   wire            wr;
   wire            rd;
   wire            clr_status;
   wire            miss;
   wire [NDEV-1:0] hit;

   assign acc        = psel & penable & ~pready;
   assign wr         = acc & pwrite;
   assign rd         = acc & ~pwrite;
   assign clr_status = wr & sel_status & pwdata[0];
   assign miss       = bus_valid & ~|hit;

   // ----------------------------------------
   // APB address decode
   // ----------------------------------------
   always @* begin
      sel_d0_low  = 1'b0;
      sel_d0_high = 1'b0;
      sel_d1_low  = 1'b0;
      sel_d1_high = 1'b0;
      sel_d2_low  = 1'b0;
      sel_d2_high = 1'b0;
      sel_d3_low  = 1'b0;
      sel_d3_high = 1'b0;
      sel_status  = 1'b0;
      sel_none    = 1'b0;
      if (paddr == `SRAD_OFF_D0_LOW) begin
         sel_d0_low = 1'b1;
      end else if (paddr == `SRAD_OFF_D0_HIGH) begin
         sel_d0_high = 1'b1;
      end else if (paddr == `SRAD_OFF_D1_LOW) begin
         sel_d1_low = 1'b1;
      end else if (paddr == `SRAD_OFF_D1_HIGH) begin
         sel_d1_high = 1'b1;
      end else if (paddr == `SRAD_OFF_D2_LOW) begin
         sel_d2_low = 1'b1;
      end else if (paddr == `SRAD_OFF_D2_HIGH) begin
         sel_d2_high = 1'b1;
      end else if (paddr == `SRAD_OFF_D3_LOW) begin
         sel_d3_low = 1'b1;
      end else if (paddr == `SRAD_OFF_D3_HIGH) begin
         sel_d3_high = 1'b1;
      end else if (paddr == `SRAD_OFF_STATUS) begin
         sel_status = 1'b1;
      end else begin
         sel_none = 1'b1;
      end
   end

   // ----------------------------------------
   // Device 0 window
   // ----------------------------------------
   always @* begin
      device0_window_low_d  = device0_window_low_q;
      device0_window_high_d = device0_window_high_q;
      if (wr & sel_d0_low) begin
         device0_window_low_d  = pwdata;
         device0_window_high_d = {pwdata[31:28], device0_window_high_q[27:0]};
      end else if (wr & sel_d0_high) begin
         device0_window_high_d = {device0_window_low_q[31:28], pwdata[27:0]};
      end
   end

   always @(posedge clock) begin
      if (!nrst) begin
         device0_window_low_q  <= `SRAD_RST_D0_LOW;
         device0_window_high_q <= `SRAD_RST_D0_HIGH;
      end else begin
         device0_window_low_q  <= device0_window_low_d;
         device0_window_high_q <= device0_window_high_d;
      end
   end

   // ----------------------------------------
   // Device 1 window
   // ----------------------------------------
   always @* begin
      device1_window_low_d  = device1_window_low_q;
      device1_window_high_d = device1_window_high_q;
      if (wr & sel_d1_low) begin
         device1_window_low_d  = pwdata;
         device1_window_high_d = {pwdata[31:28], device1_window_high_q[27:0]};
      end else if (wr & sel_d1_high) begin
         device1_window_high_d = {device1_window_low_q[31:28], pwdata[27:0]};
      end
   end

   always @(posedge clock) begin
      if (!nrst) begin
         device1_window_low_q  <= `SRAD_RST_D1_LOW;
         device1_window_high_q <= `SRAD_RST_D1_HIGH;
      end else begin
         device1_window_low_q  <= device1_window_low_d;
         device1_window_high_q <= device1_window_high_d;
      end
   end

   // ----------------------------------------
   // Device 2 window
   // ----------------------------------------
   always @* begin
      device2_window_low_d  = device2_window_low_q;
      device2_window_high_d = device2_window_high_q;
      if (wr & sel_d2_low) begin
         device2_window_low_d  = pwdata;
         device2_window_high_d = {pwdata[31:28], device2_window_high_q[27:0]};
      end else if (wr & sel_d2_high) begin
         device2_window_high_d = {device2_window_low_q[31:28], pwdata[27:0]};
      end
   end

   always @(posedge clock) begin
      if (!nrst) begin
         device2_window_low_q  <= `SRAD_RST_D2_LOW;
         device2_window_high_q <= `SRAD_RST_D2_HIGH;
      end else begin
         device2_window_low_q  <= device2_window_low_d;
         device2_window_high_q <= device2_window_high_d;
      end
   end

   // ----------------------------------------
   // Device 3 window
   // ----------------------------------------
   always @* begin
      device3_window_low_d  = device3_window_low_q;
      device3_window_high_d = device3_window_high_q;
      if (wr & sel_d3_low) begin
         device3_window_low_d  = pwdata;
         device3_window_high_d = {pwdata[31:28], device3_window_high_q[27:0]};
      end else if (wr & sel_d3_high) begin
         device3_window_high_d = {device3_window_low_q[31:28], pwdata[27:0]};
      end
   end

   always @(posedge clock) begin
      if (!nrst) begin
         device3_window_low_q  <= `SRAD_RST_D3_LOW;
         device3_window_high_q <= `SRAD_RST_D3_HIGH;
      end else begin
         device3_window_low_q  <= device3_window_low_d;
         device3_window_high_q <= device3_window_high_d;
      end
   end

   // ----------------------------------------
   // APB read mux and answer
   // ----------------------------------------
   always @* begin
      rd_d = 32'h0000_0000;
      if (sel_d0_low) begin
         rd_d = device0_window_low_q;
      end else if (sel_d0_high) begin
         rd_d = device0_window_high_q;
      end else if (sel_d1_low) begin
         rd_d = device1_window_low_q;
      end else if (sel_d1_high) begin
         rd_d = device1_window_high_q;
      end else if (sel_d2_low) begin
         rd_d = device2_window_low_q;
      end else if (sel_d2_high) begin
         rd_d = device2_window_high_q;
      end else if (sel_d3_low) begin
         rd_d = device3_window_low_q;
      end else if (sel_d3_high) begin
         rd_d = device3_window_high_q;
      end else if (sel_status) begin
         rd_d = {last_addr_q, 19'h0_0000, last_unclaimed_q};
      end
   end

   always @(posedge clock) begin
      if (!nrst) begin
         pready <= 1'b0;
      end else begin
         pready <= acc;
      end
   end

   always @(posedge clock) begin
      if (!nrst) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= acc & sel_none;
      end
   end

   always @(posedge clock) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= rd ? rd_d : 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Decode, one comparator per device
   // ----------------------------------------
   srad_window_match u_match0 (
      .addr     (bus_physical_address),
      .win_low  (device0_window_low_q),
      .win_high (device0_window_high_q),
      .hit      (hit[0])
   );

   srad_window_match u_match1 (
      .addr     (bus_physical_address),
      .win_low  (device1_window_low_q),
      .win_high (device1_window_high_q),
      .hit      (hit[1])
   );

   srad_window_match u_match2 (
      .addr     (bus_physical_address),
      .win_low  (device2_window_low_q),
      .win_high (device2_window_high_q),
      .hit      (hit[2])
   );

   srad_window_match u_match3 (
      .addr     (bus_physical_address),
      .win_low  (device3_window_low_q),
      .win_high (device3_window_high_q),
      .hit      (hit[3])
   );

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   // Selects lag the address by one clock
   always @(posedge clock) begin
      if (!nrst) begin
         memory_chip_select_n <= {NDEV{1'b1}};
      end else if (bus_valid) begin
         memory_chip_select_n <= ~hit;
      end else begin
         memory_chip_select_n <= {NDEV{1'b1}};
      end
   end

   always @(posedge clock) begin
      if (!nrst) begin
         bus_unclaimed <= 1'b0;
      end else begin
         bus_unclaimed <= miss;
      end
   end

   always @(posedge clock) begin
      if (!nrst) begin
         bus_decoded <= 1'b0;
      end else begin
         bus_decoded <= bus_valid;
      end
   end

   // ----------------------------------------
   // Unclaimed status capture
   // ----------------------------------------
   // A new miss wins over a clear in the same cycle
   always @(posedge clock) begin
      if (!nrst) begin
         last_addr_q      <= 12'h000;
         last_unclaimed_q <= 1'b0;
      end else if (miss) begin
         last_addr_q      <= bus_physical_address[31:20];
         last_unclaimed_q <= 1'b1;
      end else if (clr_status) begin
         last_unclaimed_q <= 1'b0;
      end
   end
endmodule // srad_decoder

// ===== verif/srad_properties.sv
`timescale 1ns/1ps
// ----
// Decoder port checks
// ----
module srad_properties #(parameter NDEV = 4) (
   input wire            clock,
   input wire            nrst,
   input wire            psel,
   input wire            penable,
   input wire            pready,
   input wire            pslverr,
   input wire            bus_valid,
   input wire [NDEV-1:0] memory_chip_select_n,
   input wire            bus_unclaimed,
   input wire            bus_decoded
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   property p_one; $onehot0(~memory_chip_select_n); endproperty
   a_one: assert property (p_one) else $error("two selects");
   property p_idle; !bus_valid |=> &memory_chip_select_n && !bus_unclaimed; endproperty
   a_idle: assert property (p_idle) else $error("select idle");
   property p_unc; bus_valid |=> bus_unclaimed == &memory_chip_select_n; endproperty
   a_unc: assert property (p_unc) else $error("unclaimed");
   property p_dec; bus_valid ##1 !bus_valid |-> bus_decoded ##1 !bus_decoded; endproperty
   a_dec: assert property (p_dec) else $error("decoded");
   property p_rdy; psel && penable && !pready |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready");
   property p_pls; pready |=> !pready; endproperty
   a_pls: assert property (p_pls) else $error("long ready");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("lone error");
   property p_ord; !(psel && penable) |=> !pready; endproperty
   a_ord: assert property (p_ord) else $error("stray ready");
endmodule // srad_properties
bind srad_decoder srad_properties #(.NDEV(NDEV)) u_props (
   .clock                (clock),
   .nrst                 (nrst),
   .psel                 (psel),
   .penable              (penable),
   .pready               (pready),
   .pslverr              (pslverr),
   .bus_valid            (bus_valid),
   .memory_chip_select_n (memory_chip_select_n),
   .bus_unclaimed        (bus_unclaimed),
   .bus_decoded          (bus_decoded)
);

// ===== verif/srad_bus_master.sv
`timescale 1ns/1ps
// ----
// Processor side address source
// ----
module srad_bus_master (
   input  wire         clock,
   output logic        bus_valid,
   output logic [31:0] bus_physical_address
);
   initial bus_valid = 1'h0;
   initial bus_physical_address = 32'h0000_0000;
   task automatic issue(input logic [31:0] a);
      @(posedge clock);
      bus_valid <= 1'h1;
      bus_physical_address <= a;
      @(posedge clock);
      bus_valid <= 1'h0;
      bus_physical_address <= ~a; // Stale address never lingers
   endtask
endmodule // srad_bus_master

// ===== verif/test_sdram_region_address_decoder.sv
`timescale 1ns/1ps
// ----
// Scenarios
// ----
module test_sdram_region_address_decoder;
   logic        clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr;
   logic        bus_valid, bus_unclaimed, bus_decoded;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdat, bus_physical_address;
   logic [3:0]  memory_chip_select_n;
   int          error_cnt = 0, checks = 0;
   always #50 clock = ~clock;
   srad_bus_master u_cpu (
      .clock                (clock),
      .bus_valid            (bus_valid),
      .bus_physical_address (bus_physical_address)
   );
   srad_decoder u_dut (
      .clock                (clock),
      .nrst                 (nrst),
      .psel                 (psel),
      .penable              (penable),
      .pwrite               (pwrite),
      .paddr                (paddr),
      .pwdata               (pwdata),
      .prdata               (prdata),
      .pready               (pready),
      .pslverr              (pslverr),
      .bus_valid            (bus_valid),
      .bus_physical_address (bus_physical_address),
      .memory_chip_select_n (memory_chip_select_n),
      .bus_unclaimed        (bus_unclaimed),
      .bus_decoded          (bus_decoded)
   );
   task automatic results();
      if (error_cnt == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, s);
      checks++;
      if (s !== e)
         error_cnt++;
      if (s !== e)
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      do @(posedge clock); while (pready !== 1'h1 && ++n < 20);
      if (n >= 20) begin
         error_cnt++;
         results();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic dec(input logic [31:0] a, input logic [3:0] e);
      u_cpu.issue(a);
      #1;
      cmp("select", {28'h0, e}, {28'h0, memory_chip_select_n});
      cmp("unclaimed", {31'h0, &e}, {31'h0, bus_unclaimed});
      cmp("decoded", 32'h1, {31'h0, bus_decoded});
   endtask
   task automatic t_reset();
      for (int i = 0; i < 4; i++) begin
         apb(1'h0, 12'(8 * i), 32'h0);
         cmp("low", i * 32'h0080_0000, rdat);
         apb(1'h0, 12'(8 * i + 4), 32'h0);
         cmp("high", i * 32'h0080_0000 + 32'h007F_FFFF, rdat);
         dec(i * 32'h0080_0000, ~(4'h1 << i));
         dec(i * 32'h0080_0000 + 32'h007F_FFFF, ~(4'h1 << i));
      end
      dec(32'h0200_0000, 4'hF);
      apb(1'h0, 12'h020, 32'h0);
      cmp("status", 32'h0200_0001, rdat);
      apb(1'h1, 12'h020, 32'h1);
      apb(1'h0, 12'h020, 32'h0);
      cmp("status", 32'h0200_0000, rdat);
   endtask
   task automatic t_bounds();
      apb(1'h1, 12'h000, 32'h3120_0000);
      apb(1'h1, 12'h004, 32'h3140_0000);
      dec(32'h311F_FFFF, 4'hF);
      dec(32'h3120_0000, 4'hE);
      dec(32'h314F_FFFF, 4'hE);
      dec(32'h3150_0000, 4'hF);
      dec(32'h4120_0000, 4'hF);
   endtask
   task automatic t_cross();
      apb(1'h1, 12'h008, 32'h5000_0000);
      apb(1'h1, 12'h00C, 32'h6060_0000);
      apb(1'h0, 12'h00C, 32'h0);
      cmp("high", 32'h5060_0000, rdat);
      dec(32'h5060_0000, 4'hD);
      dec(32'h6030_0000, 4'hF);
   endtask
   task automatic t_off();
      apb(1'h1, 12'h010, 32'h0180_0000);
      dec(32'h0170_0000, 4'hF);
      dec(32'h0180_0000, 4'h7);
      apb(1'h0, 12'h024, 32'h0);
      cmp("slverr", 32'h1, {31'h0, rerr});
      apb(1'h1, 12'h024, 32'hFFFF_FFFF);
      cmp("slverr", 32'h1, {31'h0, rerr});
   endtask
   task automatic t_rerst();
      @(posedge clock);
      nrst <= 1'h0;
      repeat (2) @(posedge clock);
      nrst <= 1'h1;
      apb(1'h0, 12'h010, 32'h0);
      cmp("low", 32'h0100_0000, rdat);
      apb(1'h0, 12'h00C, 32'h0);
      cmp("high", 32'h00FF_FFFF, rdat);
      apb(1'h0, 12'h020, 32'h0);
      cmp("status", 32'h0, rdat);
      dec(32'h0170_0000, 4'hB);
   endtask
   initial begin
      repeat (8) @(posedge clock);
      nrst <= 1'h1;
      t_reset();
      t_bounds();
      t_cross();
      t_off();
      t_rerst();
      results();
   end
endmodule // test_sdram_region_address_decoder
